/* flash_status_write_protect.sv */
// status registers, write protection and command filter of a serial flash
`include "flash_wp_defines.svh"

module flash_status_write_protect #(
	parameter logic [16:0] LOCKOUT_CYC = 17'(`PUW_CYC)
) (
	input  wire logic                      core_clk,
	input  wire logic                      rst,
	input  wire logic                      spi_clk,
	input  wire logic                      cs_n,
	input  wire logic                      mosi,
	output logic                           miso,
	output logic                           miso_oe,
	input  wire logic                      wp_n,
	input  wire logic                      hold_reset_n,
	input  wire logic                      op_done,
	output logic                           op_req,
	output flash_wp_pkg::op_kind_e         op_kind,
	output logic [23:0]                    op_addr,
	output logic                           suspend_req,
	output logic                           resume_req,
	output logic                           busy,
	output logic                           deep_sleep_state,
	output logic                           quad_io_enable,
	output logic                           wp_active,
	output logic                           hold_active,
	output logic                           reset_active,
	output logic [6:0]                     drive_pct,
	output logic                           fast_standby_select,
	output logic [2:0]                     otp_lock
);

	// ==================================================================
	// link domain: frame collection
	flash_wp_pkg::frame_s frame_ff;
	flash_wp_pkg::snap_s  snap_ff;
	logic                 in_frame_ff;
	logic [2:0]           bit_ff;
	logic [6:0]           shift_ff;
	logic                 frame_tog_ff;
	logic [7:0]           rx_byte;
	logic [7:0]           rd_byte;
	logic                 rd_cmd;

	assign rx_byte = {shift_ff, mosi};

	// chip select high clears the frame marker; the frame fields stay put for the core
	always_ff @(posedge spi_clk or posedge cs_n or posedge rst) begin
		if (cs_n || rst) begin
			in_frame_ff <= 1'b0;
		end else begin
			in_frame_ff <= 1'b1;
		end
	end

	always_ff @(posedge spi_clk or posedge rst) begin
		if (rst) begin
			frame_ff     <= '0;
			bit_ff       <= 3'h0;
			shift_ff     <= 7'h00;
			frame_tog_ff <= 1'b0;
		end else if (!in_frame_ff) begin
			frame_tog_ff <= ~frame_tog_ff;
			bit_ff       <= 3'h1;
			shift_ff     <= {6'h00, mosi};
			frame_ff     <= '0;
		end else begin
			bit_ff           <= bit_ff + 3'h1;
			shift_ff         <= rx_byte[6:0];
			frame_ff.aligned <= (bit_ff == 3'h7);
			if (bit_ff == 3'h7) begin
				if (frame_ff.nbytes == 3'h0) begin
					frame_ff.opcode <= rx_byte;
				end else if (frame_ff.nbytes < 3'h4) begin
					frame_ff.args <= {frame_ff.args[15:0], rx_byte};
				end
				if (frame_ff.nbytes != 3'h7) begin
					frame_ff.nbytes <= frame_ff.nbytes + 3'h1;
				end
			end
		end
	end

	// ==================================================================
	// link domain: status read-out
	always_comb begin
		rd_cmd  = 1'b1;
		rd_byte = snap_ff.sr1;
		case (frame_ff.opcode)
			`CMD_RDSR1: rd_byte = snap_ff.sr1;
			`CMD_RDSR2: rd_byte = snap_ff.sr2;
			`CMD_RDSR3: rd_byte = snap_ff.sr3;
			default:    rd_cmd  = 1'b0;
		endcase
	end

	// snapshot is frozen while chip select is low, so reading it here is safe
	always_ff @(negedge spi_clk or posedge rst or posedge cs_n) begin
		if (rst || cs_n) begin
			miso    <= 1'b0;
			miso_oe <= 1'b0;
		end else if (in_frame_ff && frame_ff.nbytes != 3'h0 && rd_cmd && !snap_ff.sleep) begin
			miso    <= rd_byte[~bit_ff];
			miso_oe <= 1'b1;
		end
	end

	// ==================================================================
	// core domain: synchronisers
	logic cs_s1_ff, cs_s2_ff, cs_s3_ff;
	logic tg_s1_ff, tg_s2_ff, tg_seen_ff;
	logic wp_s1_ff, wp_s2_ff;
	logic hr_s1_ff, hr_s2_ff;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			{cs_s1_ff, cs_s2_ff, cs_s3_ff} <= 3'h7;
			{tg_s1_ff, tg_s2_ff, tg_seen_ff} <= 3'h0;
			{wp_s1_ff, wp_s2_ff} <= 2'h3;
			{hr_s1_ff, hr_s2_ff} <= 2'h3;
		end else begin
			cs_s1_ff <= cs_n;
			cs_s2_ff <= cs_s1_ff;
			cs_s3_ff <= cs_s2_ff;
			tg_s1_ff <= frame_tog_ff;
			tg_s2_ff <= tg_s1_ff;
			if (cs_s2_ff && !cs_s3_ff) begin
				tg_seen_ff <= tg_s2_ff;
			end
			wp_s1_ff <= wp_n;
			wp_s2_ff <= wp_s1_ff;
			hr_s1_ff <= hold_reset_n;
			hr_s2_ff <= hr_s1_ff;
		end
	end

	// ==================================================================
	// core domain: state and decode
	flash_wp_pkg::state_e state_ff;
	logic [7:0]  sr1_ff, sr2_ff, sr3_ff;
	logic [7:0]  nv_sr1_ff, nv_sr2_ff, nv_sr3_ff;
	logic [2:0]  otp_ff;
	logic        wel_ff, vol_en_ff, paused_ff, sleep_ff;
	logic [9:0]  tw_cnt_ff;
	logic [16:0] lock_cnt_ff;
	logic        frame_go, cmd_ok, is_busy, hw_locked, lockout, quad;
	logic        is_wrsr, is_pe, wr1, wr2, wr3, sr_write_go, pe_go, nv_write;
	logic [7:0]  op, val_a, val_b, v2;
	logic [23:0] rng_lo, rng_hi, mask;
	logic        hit;

	function automatic logic prot_hit(input logic [7:0] s1, input logic cmp,
			input logic [23:0] lo, input logic [23:0] hi);
		logic [2:0]  lvl;
		logic [23:0] size, r_lo, r_hi, p_lo, p_hi;
		logic        none, all;
		begin
			lvl  = s1[`SR1_BP_HI:`SR1_BP_LO];
			size = (s1[`SR1_SMALL] ? `SEC_UNIT : `BLK_UNIT) << (lvl - 3'h1);
			if (s1[`SR1_SMALL] && size > `SEC_CAP) begin
				size = `SEC_CAP;
			end
			r_lo = s1[`SR1_ORIGIN] ? 24'h00_0000 : `ARRAY_END - size;
			r_hi = s1[`SR1_ORIGIN] ? size - 24'h00_0001 : `ARRAY_TOP;
			none = (lvl == 3'h0);
			all  = (lvl == 3'h7);
			p_lo = r_lo;
			p_hi = r_hi;
			if (cmp) begin
				p_lo = s1[`SR1_ORIGIN] ? r_hi + 24'h00_0001 : 24'h00_0000;
				p_hi = s1[`SR1_ORIGIN] ? `ARRAY_TOP : r_lo - 24'h00_0001;
				none = (lvl == 3'h7);
				all  = (lvl == 3'h0);
			end
			if (all) begin
				p_lo = 24'h00_0000;
				p_hi = `ARRAY_TOP;
			end
			prot_hit = !none && lo <= p_hi && hi >= p_lo;
		end
	endfunction

	assign op        = frame_ff.opcode;
	assign frame_go  = cs_s2_ff && !cs_s3_ff && (tg_s2_ff != tg_seen_ff);
	assign quad      = sr2_ff[`SR2_QUAD];
	assign cmd_ok    = !(!quad && sr3_ff[`SR3_PINFN] && !hr_s2_ff);
	assign is_busy   = (state_ff == flash_wp_pkg::ST_SRW) || (state_ff == flash_wp_pkg::ST_ARRAY);
	assign hw_locked = sr1_ff[`SR1_LOCK] && !quad && !wp_s2_ff;
	assign lockout   = (lock_cnt_ff != 17'h0_0000);
	assign is_wrsr   = (op == `CMD_WRSR1) || (op == `CMD_WRSR2) || (op == `CMD_WRSR3);
	assign wr1       = (op == `CMD_WRSR1);
	assign wr2       = (op == `CMD_WRSR2) || (wr1 && frame_ff.nbytes >= 3'h3);
	assign wr3       = (op == `CMD_WRSR3);
	assign val_a     = (frame_ff.nbytes >= 3'h3 && wr1) ? frame_ff.args[15:8] : frame_ff.args[7:0];
	assign val_b     = frame_ff.args[7:0];
	assign v2        = wr1 ? val_b : val_a;
	assign nv_write  = !vol_en_ff;

	always_comb begin
		is_pe = 1'b1;
		mask  = `PAGE_MASK;
		case (op)
			`CMD_PP:   mask = `PAGE_MASK;
			`CMD_SE:   mask = `SEC_MASK;
			`CMD_BE32: mask = `B32_MASK;
			`CMD_BE64: mask = `B64_MASK;
			`CMD_CE1,
			`CMD_CE2:  mask = `ARRAY_TOP;
			default:   is_pe = 1'b0;
		endcase
	end

	assign rng_lo = (mask == `ARRAY_TOP) ? 24'h00_0000 : frame_ff.args & ~mask;
	assign rng_hi = (mask == `ARRAY_TOP) ? `ARRAY_TOP : frame_ff.args | mask;
	assign hit    = prot_hit(sr1_ff, sr2_ff[`SR2_INVERT], rng_lo, rng_hi);

	// the write gate: aligned frame, not busy or asleep, lockout over
	assign sr_write_go = frame_go && cmd_ok && !sleep_ff && state_ff == flash_wp_pkg::ST_IDLE
		&& frame_ff.aligned && is_wrsr && frame_ff.nbytes >= 3'h2 && !lockout
		&& (wel_ff || vol_en_ff) && !hw_locked;
	assign pe_go = frame_go && cmd_ok && !sleep_ff && state_ff == flash_wp_pkg::ST_IDLE
		&& frame_ff.aligned && is_pe && !lockout && wel_ff && !hit
		&& (frame_ff.nbytes >= 3'h4 || mask == `ARRAY_TOP);

	// ==================================================================
	// core domain: status registers
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sr1_ff    <= `SR1_RST;
			sr2_ff    <= `SR2_RST;
			sr3_ff    <= `SR3_RST;
			nv_sr1_ff <= `SR1_RST;
			nv_sr2_ff <= `SR2_RST;
			nv_sr3_ff <= `SR3_RST;
			otp_ff    <= 3'h0;
		end else if (sr_write_go) begin
			if (wr1) begin
				sr1_ff <= (sr1_ff & ~`SR1_WMASK) | (val_a & `SR1_WMASK);
			end
			if (wr2) begin
				sr2_ff <= (sr2_ff & ~`SR2_WMASK) | (v2 & `SR2_WMASK);
			end
			if (wr3) begin
				sr3_ff <= (sr3_ff & ~`SR3_WMASK) | (val_a & `SR3_WMASK);
			end
			if (nv_write) begin
				if (wr1) begin
					nv_sr1_ff <= (nv_sr1_ff & ~`SR1_WMASK) | (val_a & `SR1_WMASK);
				end
				if (wr2) begin
					nv_sr2_ff <= (nv_sr2_ff & ~`SR2_WMASK) | (v2 & `SR2_WMASK);
					otp_ff    <= otp_ff | v2[`SR2_LB_HI:`SR2_LB_LO];
				end
				if (wr3) begin
					nv_sr3_ff <= (nv_sr3_ff & ~`SR3_WMASK) | (val_a & `SR3_WMASK);
				end
			end // volatile writes leave the copies and lock bits alone
		end
	end

	// ==================================================================
	// core domain: sequencing, latch and flags
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_ff    <= flash_wp_pkg::ST_IDLE;
			wel_ff      <= 1'b0;
			vol_en_ff   <= 1'b0;
			paused_ff   <= 1'b0;
			sleep_ff    <= 1'b0;
			tw_cnt_ff   <= 10'h000;
			lock_cnt_ff <= LOCKOUT_CYC;
			op_req      <= 1'b0;
			op_kind     <= flash_wp_pkg::OP_PROG;
			op_addr     <= 24'h00_0000;
			suspend_req <= 1'b0;
			resume_req  <= 1'b0;
		end else begin
			op_req      <= 1'b0;
			suspend_req <= 1'b0;
			resume_req  <= 1'b0;
			if (lockout) begin
				lock_cnt_ff <= lock_cnt_ff - 17'h0_0001;
			end
			if (frame_go && cmd_ok && !sleep_ff) begin
				vol_en_ff <= 1'b0;
			end
			case (state_ff)
				flash_wp_pkg::ST_IDLE: begin
					if (frame_go && cmd_ok && frame_ff.aligned) begin
						if (sleep_ff) begin
							sleep_ff <= (op != `CMD_WAKE);
						end else if (op == `CMD_WREN && !lockout) begin
							wel_ff <= 1'b1;
						end else if (op == `CMD_VWREN && !lockout) begin
							vol_en_ff <= 1'b1;
						end else if (op == `CMD_WRDI) begin
							wel_ff <= 1'b0;
						end else if (op == `CMD_DSLEEP) begin
							sleep_ff <= 1'b1;
						end
					end
					if (sr_write_go && nv_write) begin
						state_ff  <= flash_wp_pkg::ST_SRW;
						tw_cnt_ff <= 10'(`TW_CYC - 1);
					end
					if (pe_go) begin
						state_ff <= flash_wp_pkg::ST_ARRAY;
						op_req   <= 1'b1;
						op_kind  <= (op == `CMD_PP) ? flash_wp_pkg::OP_PROG : flash_wp_pkg::OP_ERASE;
						op_addr  <= rng_lo;
					end
				end
				flash_wp_pkg::ST_SRW: begin
					tw_cnt_ff <= tw_cnt_ff - 10'h001;
					if (tw_cnt_ff == 10'h000) begin
						state_ff <= flash_wp_pkg::ST_IDLE;
						wel_ff   <= 1'b0;
					end
				end
				flash_wp_pkg::ST_ARRAY: begin
					if (op_done) begin
						state_ff <= flash_wp_pkg::ST_IDLE;
						wel_ff   <= 1'b0;
					end else if (frame_go && cmd_ok && op == `CMD_SUSP) begin
						state_ff    <= flash_wp_pkg::ST_PAUSED;
						paused_ff   <= 1'b1;
						suspend_req <= 1'b1;
					end
				end
				flash_wp_pkg::ST_PAUSED: begin
					if (frame_go && cmd_ok && op == `CMD_RESUME) begin
						state_ff   <= flash_wp_pkg::ST_ARRAY;
						paused_ff  <= 1'b0;
						resume_req <= 1'b1;
					end
				end
				default: state_ff <= flash_wp_pkg::ST_IDLE;
			endcase
		end
	end

	// ==================================================================
	// core domain: snapshot for the link and registered outputs
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			snap_ff <= '0;
		end else if (cs_s2_ff) begin
			// updated only between frames; the first read bit needs it eight edges later
			snap_ff.sr1   <= {sr1_ff[7:2], wel_ff, is_busy};
			snap_ff.sr2   <= {paused_ff, sr2_ff[`SR2_INVERT], otp_ff, 1'b0, quad, 1'b0};
			snap_ff.sr3   <= sr3_ff & `SR3_WMASK;
			snap_ff.sleep <= sleep_ff;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			busy                <= 1'b0;
			deep_sleep_state    <= 1'b0;
			quad_io_enable      <= 1'b0;
			wp_active           <= 1'b1;
			hold_active         <= 1'b1;
			reset_active        <= 1'b0;
			drive_pct           <= `DRV_PCT_00;
			fast_standby_select <= 1'b1;
			otp_lock            <= 3'h0;
		end else begin
			busy                <= is_busy;
			deep_sleep_state    <= sleep_ff;
			quad_io_enable      <= quad;
			wp_active           <= !quad;
			hold_active         <= !quad && !sr3_ff[`SR3_PINFN];
			reset_active        <= !quad && sr3_ff[`SR3_PINFN];
			fast_standby_select <= sr3_ff[`SR3_FAST];
			otp_lock            <= otp_ff;
			case (sr3_ff[`SR3_DRV_HI:`SR3_DRV_LO])
				2'b00:   drive_pct <= `DRV_PCT_00;
				2'b01:   drive_pct <= `DRV_PCT_01;
				2'b10:   drive_pct <= `DRV_PCT_10;
				default: drive_pct <= `DRV_PCT_11;
			endcase
		end
	end

	// ==================================================================
	// checks
	property p_prot;
		@(posedge core_clk) disable iff (rst) pe_go |-> !hit;
	endproperty
	a_prot: assert property (p_prot) else $error("protected range accepted");

	property p_hwlock;
		@(posedge core_clk) disable iff (rst)
			(sr1_ff[`SR1_LOCK] && !quad && !wp_s2_ff) |=> $stable(sr1_ff) && $stable(sr2_ff);
	endproperty
	a_hwlock: assert property (p_hwlock) else $error("status written while pin-locked");

	property p_otp;
		@(posedge core_clk) disable iff (rst) (otp_ff & $past(otp_ff)) == $past(otp_ff);
	endproperty
	a_otp: assert property (p_otp) else $error("lock bit returned to zero");

	property p_keep_paused;
		@(posedge core_clk) disable iff (rst) sr_write_go |=> $stable(paused_ff) && $stable(wel_ff);
	endproperty
	a_keep_paused: assert property (p_keep_paused) else $error("flag moved by write");

	property p_vol_keep;
		@(posedge core_clk) disable iff (rst) (sr_write_go && !nv_write)
			|=> $stable(nv_sr1_ff) && $stable(nv_sr2_ff) && $stable(nv_sr3_ff) && $stable(otp_ff);
	endproperty
	a_vol_keep: assert property (p_vol_keep) else $error("volatile write moved copies");

	property p_lockout;
		@(posedge core_clk) disable iff (rst)
			lockout |-> !wel_ff && !op_req && state_ff != flash_wp_pkg::ST_SRW;
	endproperty
	a_lockout: assert property (p_lockout) else $error("write accepted in lockout");

	property p_wel_end;
		@(posedge core_clk) disable iff (rst)
			(state_ff == flash_wp_pkg::ST_SRW && tw_cnt_ff == 10'h000) |=> !wel_ff && !is_busy;
	endproperty
	a_wel_end: assert property (p_wel_end) else $error("latch kept after write");

	property p_sleep;
		@(posedge core_clk) disable iff (rst) sleep_ff && $past(sleep_ff) |-> !op_req && $stable(sr1_ff);
	endproperty
	a_sleep: assert property (p_sleep) else $error("activity in deep sleep");

	property p_busy;
		@(posedge core_clk) disable iff (rst) (is_busy && frame_go) |=> $stable(sr1_ff) && !op_req;
	endproperty
	a_busy: assert property (p_busy) else $error("command obeyed while busy");

	property p_align;
		@(posedge core_clk) disable iff (rst) (frame_go && !frame_ff.aligned) |=> !op_req && $stable(sr1_ff);
	endproperty
	a_align: assert property (p_align) else $error("partial byte frame obeyed");

	property p_suspend;
		@(posedge core_clk) disable iff (rst)
			(state_ff == flash_wp_pkg::ST_ARRAY && !op_done && frame_go && cmd_ok && op == `CMD_SUSP)
			|=> paused_ff ##1 snap_ff.sr2[7] || !cs_s2_ff;
	endproperty
	a_suspend: assert property (p_suspend) else $error("suspend did not set paused flag");

	c_nv_write: cover property (@(posedge core_clk) disable iff (rst) sr_write_go && nv_write);
	c_vol_write: cover property (@(posedge core_clk) disable iff (rst) sr_write_go && !nv_write);
	c_program: cover property (@(posedge core_clk) disable iff (rst) op_req ##[1:1000] op_done);
	c_sleep: cover property (@(posedge core_clk) disable iff (rst) $rose(sleep_ff));

endmodule

/* flash_wp_defines.svh */
// constants for the status register and write protection block
`ifndef FLASH_WP_DEFINES_SVH
`define FLASH_WP_DEFINES_SVH

// ==================================================================
// command codes
`define CMD_WREN     8'h06
`define CMD_VWREN    8'h50
`define CMD_WRDI     8'h04
`define CMD_WRSR1    8'h01
`define CMD_WRSR2    8'h31
`define CMD_WRSR3    8'h11
`define CMD_RDSR1    8'h05
`define CMD_RDSR2    8'h35
`define CMD_RDSR3    8'h15
`define CMD_PP       8'h02
`define CMD_SE       8'h20
`define CMD_BE32     8'h52
`define CMD_BE64     8'hd8
`define CMD_CE1      8'hc7
`define CMD_CE2      8'h60
`define CMD_SUSP     8'h75
`define CMD_RESUME   8'h7a
`define CMD_DSLEEP   8'hb9
`define CMD_WAKE     8'hab

// ==================================================================
// field positions and reset values
`define SR1_BP_LO    2
`define SR1_BP_HI    4
`define SR1_ORIGIN   5
`define SR1_SMALL    6
`define SR1_LOCK     7
`define SR2_QUAD     1
`define SR2_LB_LO    3
`define SR2_LB_HI    5
`define SR2_INVERT   6
`define SR3_GUARD    2
`define SR3_FAST     4
`define SR3_DRV_LO   5
`define SR3_DRV_HI   6
`define SR3_PINFN    7
`define SR1_WMASK    8'hfc
`define SR2_WMASK    8'h42
`define SR3_WMASK    8'hf4
`define SR1_RST      8'h00
`define SR2_RST      8'h00
`define SR3_RST      8'h10

// ==================================================================
// array geometry
`define ARRAY_TOP    24'h3f_ffff
`define ARRAY_END    24'h40_0000
`define SEC_UNIT     24'h00_1000
`define BLK_UNIT     24'h01_0000
`define SEC_CAP      24'h00_8000
`define PAGE_MASK    24'h00_00ff
`define SEC_MASK     24'h00_0fff
`define B32_MASK     24'h00_7fff
`define B64_MASK     24'h00_ffff

// ==================================================================
// drive strength in percent
`define DRV_PCT_00   7'h32
`define DRV_PCT_01   7'h19
`define DRV_PCT_10   7'h4b
`define DRV_PCT_11   7'h64

// ==================================================================
// timing
`define CLK_MHZ      100
`define TW_US        10
`define TW_CYC       (`TW_US * `CLK_MHZ)
`define PUW_US       1000
`define PUW_CYC      (`PUW_US * `CLK_MHZ)

`endif

/* flash_wp_pkg.sv */
// types shared by the status register and write protection block
package flash_wp_pkg;

	typedef enum logic [3:0] {
		ST_IDLE   = 4'b0001,
		ST_SRW    = 4'b0010,
		ST_ARRAY  = 4'b0100,
		ST_PAUSED = 4'b1000
	} state_e;

	typedef enum logic [1:0] {
		OP_PROG  = 2'b01,
		OP_ERASE = 2'b10
	} op_kind_e;

	// one serial frame as collected on the link clock
	typedef struct packed {
		logic [7:0]  opcode;
		logic [23:0] args;
		logic [2:0]  nbytes;
		logic        aligned;
	} frame_s;

	// status image frozen for the link while a frame runs
	typedef struct packed {
		logic [7:0] sr1;
		logic [7:0] sr2;
		logic [7:0] sr3;
		logic       sleep;
	} snap_s;

endpackage

/* spi_host_model.sv */
// serial host model: mode 0 frames on chip select and link clock
module spi_host_model (
	output logic      spi_clk,
	output logic      cs_n,
	output logic      mosi,
	input  wire logic miso
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		spi_clk = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
	end
	// ==========
	// frame
	// nb bits of tx go out msb first; the clock stands low between frames
	task automatic frame(input logic [31:0] tx, input int nb, output logic [7:0] rx);
		cs_n = 1'b0;
		for (int i = 0; i < nb; i++) begin
			mosi = tx[31-i];
			#80 spi_clk = 1'b1;
			rx = {rx[6:0], miso};
			#80 spi_clk = 1'b0;
		end
		#80 cs_n = 1'b1;
		// a released line must not keep showing the last bit
		mosi = ~mosi;
		#200;
	endtask
endmodule

/* flash_status_write_protect_tb_top.sv */
// self-checking bench for the status register and write protection block
module flash_status_write_protect_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	// ==========
	// signals
	logic                   core_clk = 1'b0;
	logic                   rst = 1'b1;
	logic                   wp_n = 1'b1;
	logic                   hold_reset_n = 1'b1;
	logic                   op_done = 1'b0;
	logic                   spi_clk, cs_n, mosi, miso, miso_oe, op_req, busy;
	logic                   suspend_req, resume_req, deep_sleep_state, quad_io_enable;
	logic                   wp_active, hold_active, reset_active, fast_standby_select;
	logic [2:0]             otp_lock;
	logic [6:0]             drive_pct;
	logic [23:0]            op_addr, last_addr;
	flash_wp_pkg::op_kind_e op_kind, last_kind;
	logic [6:0]             pct [4] = '{7'h32, 7'h19, 7'h4b, 7'h64};
	int                     bad_count = 0;
	int                     checks = 0;
	int                     nreq = 0;
	int                     nsus = 0;
	int                     nres = 0;
	int                     noe = 0;
	int                     noe_mark = 0;
	always #5 core_clk = ~core_clk;
	flash_status_write_protect #(.LOCKOUT_CYC(17'h0_0190)) flash_status_write_protect_inst (
		.core_clk, .rst, .spi_clk, .cs_n, .mosi, .miso, .miso_oe, .wp_n, .hold_reset_n,
		.op_done, .op_req, .op_kind, .op_addr, .suspend_req, .resume_req, .busy,
		.deep_sleep_state, .quad_io_enable, .wp_active, .hold_active, .reset_active,
		.drive_pct, .fast_standby_select, .otp_lock);
	spi_host_model spi_host_model_inst (.spi_clk, .cs_n, .mosi, .miso);
	always @(posedge core_clk) begin
		if (op_req === 1'b1) begin
			nreq++;
			last_addr = op_addr;
			last_kind = op_kind;
		end
		if (suspend_req === 1'b1)
			nsus++;
		if (resume_req === 1'b1)
			nres++;
	end
	always @(posedge spi_clk) begin
		if (miso_oe === 1'b1)
			noe++;
	end
	// ==========
	// tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t %s got %0h exp %0h", $time, what, got, exp);
		end
	endtask
	task automatic tx(input logic [31:0] d, input int nb);
		logic [7:0] r;
		spi_host_model_inst.frame(d, nb, r);
	endtask
	task automatic rchk(input logic [7:0] op, input logic [7:0] exp);
		logic [7:0] v;
		int         n0;
		n0 = noe;
		spi_host_model_inst.frame({op, 24'h00_0000}, 16, v);
		chk(v, exp, "status read");
		chk(noe - n0, 8, "read drive cycles");
		chk(miso_oe, 1'b0, "drive after frame");
	endtask
	// busy is bounded: a status write lasts 1000 cycles
	task automatic wait_idle();
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 3000) begin
			@(negedge core_clk);
			n++;
		end
		chk(n < 3000, 1, "busy stuck");
	endtask
	task automatic wr(input logic [7:0] en, input logic [31:0] d, input int nb);
		tx({en, 24'h00_0000}, 8);
		tx(d, nb);
		wait_idle();
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// ==========
	// tests
	initial begin
		// the tests need about 190 us; over two and a half times that means a hang
		#500000;
		chk(0, 1, "watchdog expired");
		finish_test();
	end
	initial begin
		repeat (12) @(posedge core_clk);
		@(negedge core_clk);
		rst = 1'b0;
		chk({drive_pct, fast_standby_select, otp_lock, quad_io_enable}, 12'h650, "rst");
		chk({wp_active, hold_active, reset_active}, 3'h6, "pin roles");
		tx(32'h0600_0000, 8);
		rchk(8'h05, 8'h00);
		rchk(8'h35, 8'h00);
		rchk(8'h15, 8'h10);
		repeat (400) @(negedge core_clk);
		tx(32'h011c_0000, 16);
		rchk(8'h05, 8'h00);
		tx(32'h0600_0000, 8);
		tx(32'h011f_0000, 16);
		rchk(8'h05, 8'h1f);
		wait_idle();
		rchk(8'h05, 8'h1c);
		$display("test reset and status write done");
		tx(32'h0600_0000, 8);
		tx(32'h2000_0000, 32);
		chk(nreq, 0, "erase of protected");
		wr(8'h06, 32'h0104_0000, 16);
		tx(32'h0600_0000, 8);
		tx(32'h203f_0000, 32);
		tx(32'h2000_1234, 32);
		chk(nreq, 1, "erase count");
		chk(last_addr, 24'h00_1000, "erase addr");
		chk(last_kind, flash_wp_pkg::OP_ERASE, "erase kind");
		tx(32'h7500_0000, 8);
		chk(nsus, 1, "suspend pulse");
		rchk(8'h35, 8'h80);
		tx(32'h7a00_0000, 8);
		chk(nres, 1, "resume pulse");
		rchk(8'h35, 8'h00);
		@(negedge core_clk);
		op_done = 1'b1;
		@(negedge core_clk);
		op_done = 1'b0;
		wait_idle();
		rchk(8'h05, 8'h04);
		tx(32'h0600_0000, 8);
		tx(32'hc700_0000, 8);
		tx(32'h0200_2345, 32);
		chk(nreq, 2, "chip erase or program count");
		chk(last_addr, 24'h00_2300, "program addr");
		chk(last_kind, flash_wp_pkg::OP_PROG, "program kind");
		@(negedge core_clk);
		op_done = 1'b1;
		@(negedge core_clk);
		op_done = 1'b0;
		wait_idle();
		$display("test protection and suspend done");
		wr(8'h06, 32'h0184_0000, 16);
		@(negedge core_clk);
		wp_n = 1'b0;
		wr(8'h50, 32'h0100_0000, 16);
		rchk(8'h05, 8'h84);
		@(negedge core_clk);
		wp_n = 1'b1;
		wr(8'h50, 32'h0104_0000, 16);
		rchk(8'h05, 8'h04);
		wr(8'h06, 32'h0100_0000, 15);
		rchk(8'h05, 8'h06);
		tx(32'h0400_0000, 8);
		@(negedge core_clk);
		wp_n = 1'b0;
		$display("test lock mode done");
		for (int i = 0; i < 4; i++) begin
			wr(8'h50, {8'h11, 1'b0, 2'(i), 5'h00, 16'h0000}, 16);
			chk(drive_pct, pct[i], "drive");
		end
		chk(fast_standby_select, 1'b0, "standby");
		wr(8'h50, 32'h1180_0000, 16);
		chk({hold_active, reset_active}, 2'h1, "reset role");
		wr(8'h06, 32'h310a_0000, 16);
		chk({otp_lock, quad_io_enable, wp_active, reset_active}, 6'h0c, "quad");
		wr(8'h06, 32'h3102_0000, 16);
		rchk(8'h35, 8'h0a);
		$display("test config bits done");
		tx(32'hb900_0000, 8);
		chk(deep_sleep_state, 1'b1, "sleep");
		noe_mark = noe;
		tx(32'h0500_0000, 16);
		chk(noe, noe_mark, "read answered in sleep");
		tx(32'h0600_0000, 8);
		tx(32'hab00_0000, 8);
		chk(deep_sleep_state, 1'b0, "wake");
		rchk(8'h05, 8'h04);
		$display("test deep sleep done");
		finish_test();
	end
endmodule
